// >>> psm_pkg.sv
`default_nettype none

package psm_pkg;

    // =========================================================================
    // Register map
    // =========================================================================
    localparam logic [7:0] PSM_CTRL_ADDR  = 8'hDF;
    localparam logic [7:0] PSM_CTRL_RESET = 8'hDE;

    // Field positions
    localparam int PSM_BIT_RSV7   = 7;
    localparam int PSM_BIT_CMP    = 6;
    localparam int PSM_BIT_FLAG   = 5;
    localparam int PSM_BIT_TRIP_H = 4;
    localparam int PSM_BIT_TRIP_L = 3;
    localparam int PSM_BIT_RSV2   = 2;
    localparam int PSM_BIT_RSV1   = 1;
    localparam int PSM_BIT_EN     = 0;

    // Trip level codes, highest threshold first
    localparam logic [1:0] PSM_TRIP_4V37 = 2'h0;
    localparam logic [1:0] PSM_TRIP_3V08 = 2'h1;
    localparam logic [1:0] PSM_TRIP_LOW2 = 2'h2;
    localparam logic [1:0] PSM_TRIP_LOW3 = 2'h3;

    // =========================================================================
    // Timing
    // =========================================================================
    localparam int PSM_CLK_PERIOD_NS = 40;
    localparam int PSM_CLK_MHZ       = 25;
    localparam int PSM_GLITCH_NS     = 2000;
    localparam int PSM_GLITCH_CYC    = (PSM_GLITCH_NS + PSM_CLK_PERIOD_NS - 1) / PSM_CLK_PERIOD_NS;
    localparam int PSM_TICK_US       = 1000;
    localparam int PSM_TICK_CYC      = PSM_TICK_US * PSM_CLK_MHZ;
    localparam int PSM_RECOVERY_MS   = 250;
    localparam int PSM_RECOVERY_TICKS = PSM_RECOVERY_MS * 1000 / PSM_TICK_US;

    localparam int PSM_GLITCH_W = 8;
    localparam int PSM_DIV_W    = 24;
    localparam int PSM_REC_W    = 8;

    // =========================================================================
    // Types
    // =========================================================================
    typedef struct packed {
        logic       rsv7;
        logic       supply_above_trip;
        logic       supply_fail_flag;
        logic [1:0] trip_level_select;
        logic       rsv2;
        logic       rsv1;
        logic       monitor_enable_bit;
    } psm_ctrl_t;

endpackage : psm_pkg

`default_nettype wire

// >>> psm_top.sv
`default_nettype none

module psm_top #(
    parameter int unsigned TICK_CYC = psm_pkg::PSM_TICK_CYC
) (
    input  wire logic       i_core_clk,
    input  wire logic       i_reset_n,
    input  wire logic [7:0] i_sfr_addr,
    input  wire logic       i_sfr_wr,
    input  wire logic       i_sfr_rd,
    input  wire logic [7:0] i_sfr_wdata,
    output logic      [7:0] o_sfr_rdata,
    input  wire logic       i_supply_above_trip,
    input  wire logic       i_monitor_irq_enable,
    output logic      [1:0] o_trip_level_select,
    output logic            o_monitor_enable,
    output logic            o_irq
);

    // =========================================================================
    // Register access
    // =========================================================================
    psm_pkg::psm_ctrl_t ctrl_reset;
    psm_pkg::psm_ctrl_t image;
    logic               wr_hit;
    logic               rd_hit;
    logic [1:0]         trip_r;
    logic               enable_r;
    logic               flag_r;
    logic [7:0]         rdata_r;

    assign ctrl_reset = psm_pkg::psm_ctrl_t'(psm_pkg::PSM_CTRL_RESET);
    assign wr_hit     = i_sfr_wr && (i_sfr_addr == psm_pkg::PSM_CTRL_ADDR);
    assign rd_hit     = i_sfr_rd && (i_sfr_addr == psm_pkg::PSM_CTRL_ADDR);

    always_comb begin
        image                    = ctrl_reset;
        image.supply_above_trip  = i_supply_above_trip;
        image.supply_fail_flag   = flag_r;
        image.trip_level_select  = trip_r;
        image.monitor_enable_bit = enable_r;
    end

    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            trip_r   <= psm_pkg::PSM_CTRL_RESET[psm_pkg::PSM_BIT_TRIP_H:psm_pkg::PSM_BIT_TRIP_L];
            enable_r <= psm_pkg::PSM_CTRL_RESET[psm_pkg::PSM_BIT_EN];
        end else if (wr_hit) begin
            trip_r   <= i_sfr_wdata[psm_pkg::PSM_BIT_TRIP_H:psm_pkg::PSM_BIT_TRIP_L];
            enable_r <= i_sfr_wdata[psm_pkg::PSM_BIT_EN];
        end
    end

    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            rdata_r <= 8'h00;
        end else if (rd_hit) begin
            rdata_r <= image;
        end else begin
            rdata_r <= 8'h00;
        end
    end

    assign o_sfr_rdata         = rdata_r;
    assign o_trip_level_select = trip_r;
    assign o_monitor_enable    = enable_r;

    // =========================================================================
    // Glitch filter
    // =========================================================================
    logic                          filt_r;
    logic [psm_pkg::PSM_GLITCH_W-1:0] glitch_r;

    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            filt_r   <= 1'b1;
            glitch_r <= '0;
        end else if (i_supply_above_trip == filt_r) begin
            glitch_r <= '0;
        end else if (glitch_r == psm_pkg::PSM_GLITCH_W'(psm_pkg::PSM_GLITCH_CYC - 1)) begin
            filt_r   <= i_supply_above_trip;
            glitch_r <= '0;
        end else begin
            glitch_r <= glitch_r + 1'b1;
        end
    end

    // =========================================================================
    // Recovery timer
    // =========================================================================
    logic                          low_seen;
    logic                          counting;
    logic                          tick;
    logic                          expire;
    logic [psm_pkg::PSM_DIV_W-1:0] div_r;
    logic [psm_pkg::PSM_REC_W-1:0] rec_r;

    assign low_seen = enable_r && !filt_r;
    assign counting = enable_r && filt_r && flag_r;
    assign tick     = counting && (div_r == psm_pkg::PSM_DIV_W'(TICK_CYC - 1));
    assign expire   = tick && (rec_r == psm_pkg::PSM_REC_W'(psm_pkg::PSM_RECOVERY_TICKS - 1));

    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            div_r <= '0;
        end else if (!counting || tick) begin
            div_r <= '0;
        end else begin
            div_r <= div_r + 1'b1;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            rec_r <= '0;
        end else if (!counting || expire) begin
            rec_r <= '0;
        end else if (tick) begin
            rec_r <= rec_r + 1'b1;
        end
    end

    // =========================================================================
    // Supply fail flag
    // =========================================================================
    always_ff @(posedge i_core_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            flag_r <= psm_pkg::PSM_CTRL_RESET[psm_pkg::PSM_BIT_FLAG];
        end else if (low_seen) begin
            flag_r <= 1'b1;
        end else if (wr_hit) begin
            flag_r <= i_sfr_wdata[psm_pkg::PSM_BIT_FLAG];
        end else if (expire) begin
            flag_r <= 1'b0;
        end
    end

    assign o_irq = flag_r && i_monitor_irq_enable;

    // =========================================================================
    // Assertions
    // =========================================================================
    property p_trip_write;
        @(posedge i_core_clk) disable iff (!i_reset_n)
        wr_hit |=> o_trip_level_select == $past(i_sfr_wdata[psm_pkg::PSM_BIT_TRIP_H:psm_pkg::PSM_BIT_TRIP_L]);
    endproperty
    a_trip_write: assert property (p_trip_write)
        else $error("Trip field not taken from write");

    property p_trip_hold;
        @(posedge i_core_clk) disable iff (!i_reset_n)
        !wr_hit |=> $stable(o_trip_level_select);
    endproperty
    a_trip_hold: assert property (p_trip_hold)
        else $error("Trip select changed without write");

    property p_cmp_mirror;
        @(posedge i_core_clk) disable iff (!i_reset_n)
        rd_hit |=> o_sfr_rdata[psm_pkg::PSM_BIT_CMP] == $past(i_supply_above_trip);
    endproperty
    a_cmp_mirror: assert property (p_cmp_mirror)
        else $error("Status bit does not mirror comparator");

    property p_low_sets;
        @(posedge i_core_clk) disable iff (!i_reset_n)
        (enable_r && !filt_r) |=> flag_r;
    endproperty
    a_low_sets: assert property (p_low_sets)
        else $error("Low supply did not set flag");

    property p_expire_clears;
        @(posedge i_core_clk) disable iff (!i_reset_n)
        (expire && !wr_hit) |=> !flag_r && rec_r == '0;
    endproperty
    a_expire_clears: assert property (p_expire_clears)
        else $error("Recovery expiry did not clear flag");

    property p_low_restarts;
        @(posedge i_core_clk) disable iff (!i_reset_n)
        !filt_r |=> rec_r == '0 && div_r == '0;
    endproperty
    a_low_restarts: assert property (p_low_restarts)
        else $error("Recovery count not restarted");

    property p_clear_blocked;
        @(posedge i_core_clk) disable iff (!i_reset_n)
        (wr_hit && !i_sfr_wdata[psm_pkg::PSM_BIT_FLAG] && enable_r && !filt_r) |=> flag_r;
    endproperty
    a_clear_blocked: assert property (p_clear_blocked)
        else $error("Flag cleared while supply low");

    property p_irq_gate;
        @(posedge i_core_clk) disable iff (!i_reset_n)
        o_irq |-> (flag_r && i_monitor_irq_enable);
    endproperty
    a_irq_gate: assert property (p_irq_gate)
        else $error("Interrupt without enabled flag");

    property p_glitch;
        @(posedge i_core_clk) disable iff (!i_reset_n)
        (filt_r && glitch_r == '0 && !i_supply_above_trip) ##1 i_supply_above_trip |=> filt_r;
    endproperty
    a_glitch: assert property (p_glitch)
        else $error("Single-cycle glitch passed filter");

    property p_unmapped;
        @(posedge i_core_clk) disable iff (!i_reset_n)
        !rd_hit |=> o_sfr_rdata == 8'h00;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("Read data without register select");

    property p_disabled;
        @(posedge i_core_clk) disable iff (!i_reset_n)
        (!enable_r && !flag_r && !wr_hit) |=> !flag_r;
    endproperty
    a_disabled: assert property (p_disabled)
        else $error("Flag set while monitor disabled");

    property p_cov_set;
        @(posedge i_core_clk) disable iff (!i_reset_n)
        $rose(flag_r);
    endproperty
    c_cov_set: cover property (p_cov_set);

    property p_cov_expire;
        @(posedge i_core_clk) disable iff (!i_reset_n)
        expire;
    endproperty
    c_cov_expire: cover property (p_cov_expire);

    property p_cov_blocked;
        @(posedge i_core_clk) disable iff (!i_reset_n)
        wr_hit && !i_sfr_wdata[psm_pkg::PSM_BIT_FLAG] && low_seen;
    endproperty
    c_cov_blocked: cover property (p_cov_blocked);

endmodule : psm_top

`default_nettype wire

// >>> psm_supply_model.sv
`default_nettype none

module psm_supply_model #(
    parameter logic [15:0] LOW2_MV = 16'h0B72,
    parameter logic [15:0] LOW3_MV = 16'h0A46
) (
    input  wire logic [1:0]  i_trip_level_select,
    input  wire logic [15:0] i_supply_mv,
    output logic             o_supply_above_trip
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [15:0] thr_mv;

    // =========================================================================
    // Comparator against the selected threshold in millivolts
    // =========================================================================
    always_comb begin
        case (i_trip_level_select)
            2'h0:    thr_mv = 16'h1112;
            2'h1:    thr_mv = 16'h0C08;
            2'h2:    thr_mv = LOW2_MV;
            default: thr_mv = LOW3_MV;
        endcase
    end

    assign o_supply_above_trip = (i_supply_mv > thr_mv);
endmodule : psm_supply_model

`default_nettype wire

// >>> tb.sv
`default_nettype none

module tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic        clk       = 1'b0;
    logic        rst_n     = 1'b0;
    logic [7:0]  addr      = 8'h00;
    logic        wr        = 1'b0;
    logic        rd        = 1'b0;
    logic [7:0]  wdata     = 8'h00;
    logic        irq_en    = 1'b0;
    logic [15:0] supply_mv = 16'h1388;
    logic [7:0]  rdata;
    logic        above;
    logic [1:0]  trip;
    logic        mon_en;
    logic        irq;
    logic [7:0]  rd_v;
    logic [7:0]  wd;
    logic [7:0]  bad_a;
    int          miscompares = 0;
    int          n_tests     = 0;
    int          seed        = 32'h6EC860E7;

    always #20 clk = ~clk;

    psm_top #(.TICK_CYC(4)) i_psm_top (
        .i_core_clk          (clk),
        .i_reset_n           (rst_n),
        .i_sfr_addr          (addr),
        .i_sfr_wr            (wr),
        .i_sfr_rd            (rd),
        .i_sfr_wdata         (wdata),
        .o_sfr_rdata         (rdata),
        .i_supply_above_trip (above),
        .i_monitor_irq_enable(irq_en),
        .o_trip_level_select (trip),
        .o_monitor_enable    (mon_en),
        .o_irq               (irq)
    );

    psm_supply_model i_psm_supply_model (
        .i_trip_level_select(trip),
        .i_supply_mv        (supply_mv),
        .o_supply_above_trip(above)
    );

    // =========================================================================
    // Helpers
    // =========================================================================
    function automatic logic [7:0] image(input logic [7:0] w, input logic c, input logic f);
        return {1'b1, c, f, w[4:3], 2'b11, w[0]};
    endfunction : image

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic idle(input int n);
        repeat (n) @(negedge clk);
    endtask : idle

    task automatic sfr_write(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        addr  = a;
        wdata = d;
        wr    = 1'b1;
        @(negedge clk);
        wr = 1'b0;
    endtask : sfr_write

    task automatic sfr_read(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk);
        addr = a;
        rd   = 1'b1;
        @(negedge clk);
        rd = 1'b0;
        d  = rdata;
    endtask : sfr_read

    task automatic results();
        $display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : results

    // =========================================================================
    // Tests
    // =========================================================================
    initial begin
        idle(16);
        rst_n = 1'b1;
        sfr_read(psm_pkg::PSM_CTRL_ADDR, rd_v);
        check(rd_v, psm_pkg::PSM_CTRL_RESET);
        $display("Test reset done");
        for (int i = 0; i < 4; i++) begin
            wd      = 8'($random(seed));
            wd[4:3] = 2'(i);
            wd[5]   = 1'b0;
            bad_a   = 8'hDF ^ (8'h01 << i);
            sfr_write(8'hDF, wd);
            sfr_write(bad_a, ~wd);
            check({6'h00, trip}, {6'h00, wd[4:3]});
            check({7'h00, mon_en}, {7'h00, wd[0]});
            sfr_read(8'hDF, rd_v);
            check(rd_v, image(wd, 1'b1, 1'b0));
            sfr_read(bad_a, rd_v);
            check(rd_v, 8'h00);
        end
        $display("Test fields done");
        supply_mv = 16'h0DAC;
        sfr_write(8'hDF, 8'h00);
        sfr_read(8'hDF, rd_v);
        check(rd_v, 8'h86);
        sfr_write(8'hDF, 8'h08);
        sfr_read(8'hDF, rd_v);
        check(rd_v, 8'hCE);
        $display("Test trip done");
        supply_mv = 16'h1388;
        irq_en    = 1'b1;
        sfr_write(8'hDF, 8'h01);
        // Single-cycle dip, then the longest dip the filter must still reject
        supply_mv = 16'h07D0;
        idle(1);
        supply_mv = 16'h1388;
        idle(2);
        supply_mv = 16'h07D0;
        idle(49);
        supply_mv = 16'h1388;
        idle(2);
        supply_mv = 16'h07D0;
        idle(1 + ($random(seed) & 31));
        supply_mv = 16'h1388;
        idle(60);
        check({7'h00, irq}, 8'h00);
        supply_mv = 16'h07D0;
        idle(60);
        check({7'h00, irq}, 8'h01);
        irq_en = 1'b0;
        idle(1);
        check({7'h00, irq}, 8'h00);
        irq_en = 1'b1;
        sfr_write(8'hDF, 8'h01);
        sfr_read(8'hDF, rd_v);
        check(rd_v, 8'hA7);
        $display("Test flag set done");
        supply_mv = 16'h1388;
        idle(550);
        supply_mv = 16'h07D0;
        idle(60);
        check({7'h00, irq}, 8'h01);
        supply_mv = 16'h1388;
        idle(1040);
        check({7'h00, irq}, 8'h01);
        idle(20);
        check({7'h00, irq}, 8'h00);
        $display("Test recovery done");
        sfr_write(8'hDF, 8'h20);
        sfr_read(8'hDF, rd_v);
        check(rd_v, 8'hE6);
        sfr_write(8'hDF, 8'h00);
        sfr_read(8'hDF, rd_v);
        check(rd_v, 8'hC6);
        $display("Test software flag done");
        sfr_write(8'hDF, 8'h21);
        check({7'h00, irq}, 8'h01);
        rst_n = 1'b0;
        idle(2);
        check({5'h00, trip, irq}, 8'h06);
        check({7'h00, mon_en}, 8'h00);
        rst_n = 1'b1;
        sfr_read(8'hDF, rd_v);
        check(rd_v, psm_pkg::PSM_CTRL_RESET);
        $display("Test mid-run reset done");
        results();
    end

    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        $display("Watchdog expired at %0t", $time);
        results();
    end
endmodule : tb

`default_nettype wire
